//--- hw/ifs_pkg.sv
// package: constants and types for the isolated fast serial link
package ifs_pkg;
    // mode command values
    localparam logic [3:0] IFS_MODE_RESET = 4'ha;
    localparam logic [3:0] IFS_MODE_RUN = 4'h0;
    // frame layout: start, eight data bits, channel bit
    localparam int IFS_DATA_BITS = 8;
    localparam logic [3:0] IFS_LAST_DATA = 4'h7;
    // reset values
    localparam logic IFS_LINE_IDLE = 1'b1;
    localparam logic IFS_CTS_RESET = 1'b0;
    localparam logic [7:0] IFS_BYTE_RESET = 8'h00;
    localparam logic [3:0] IFS_CNT_RESET = 4'h0;
    // link clock edge detector history after reset
    localparam logic [2:0] IFS_SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {
        IFS_TX_IDLE = 2'b00,
        IFS_TX_START = 2'b01,
        IFS_TX_DATA = 2'b10,
        IFS_TX_CHAN = 2'b11
    } ifs_tx_state_t;

    typedef enum logic [1:0] {
        IFS_RX_IDLE = 2'b00,
        IFS_RX_DATA = 2'b01,
        IFS_RX_CHAN = 2'b10,
        IFS_RX_HOLD = 2'b11
    } ifs_rx_state_t;
endpackage : ifs_pkg

//--- hw/ifs_link.sv
// module: device end of the isolated fast serial link
// Function
// - link pins live on channel B only
// - mode value 10 holds transmit start, 0 releases; receive runs on
// - frame starts with low start bit
// - no transmit start during a reception
// - data byte sent LSB first
// - last bit names source channel
// - CTS falls on next rising clock edge
// - capture data bits 0..7 LSB first
// - destination_channel_bit bit routes byte, fallback other channel
// - link disabled when no channel uses mode
// - CTS stays low until byte accepted
`timescale 1ns/100ps
module ifs_link (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // configuration
    input wire logic CHA_MODE_I,
    input wire logic CHB_MODE_I,
    input wire logic MODE_WR_I,
    input wire logic [3:0] MODE_VAL_I,
    // outgoing byte from the channels
    input wire logic TX_VALID_I,
    input wire logic [7:0] TX_DATA_I,
    input wire logic TX_CHAN_I,
    output logic TX_READY_O,
    // incoming byte to the channels
    output logic RX_VALID_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_CHAN_O,
    input wire logic RX_READY_I,
    // link pins (channel B)
    input wire logic LINK_CLOCK_IN_I,
    input wire logic SERIAL_IN_LINE_I,
    output logic SERIAL_OUT_LINE_O,
    output logic LINK_CLEAR_TO_SEND_O,
    output logic LINK_PINS_ON_B_O,
    output logic LINK_HELD_O
);
    import ifs_pkg::*;

    // ************************************************
    // pin synchronisers and link clock edge
    // ************************************************
    logic [2:0] clk_sync;
    logic [1:0] din_sync;
    logic link_en;
    logic rise;
    logic fall;
    logic din;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            clk_sync <= IFS_SYNC_RESET;
            din_sync <= {2{IFS_LINE_IDLE}};
        end else begin
            clk_sync <= {clk_sync[1:0], LINK_CLOCK_IN_I};
            din_sync <= {din_sync[0], SERIAL_IN_LINE_I};
        end
    end
    assign link_en = CHA_MODE_I | CHB_MODE_I;
    assign rise = clk_sync[1] & ~clk_sync[2];
    assign fall = ~clk_sync[1] & clk_sync[2];
    assign din = din_sync[1];

    // ************************************************
    // hold control
    // ************************************************
    logic held;
    logic next_held;
    always_comb begin
        next_held = held;
        if (MODE_WR_I && MODE_VAL_I == IFS_MODE_RESET) begin
            next_held = 1'b1;
        end else if (MODE_WR_I && MODE_VAL_I == IFS_MODE_RUN) begin
            next_held = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            held <= 1'b0;
        end else begin
            held <= next_held;
        end
    end

    // ************************************************
    // receiver
    // ************************************************
    ifs_rx_state_t rx_state;
    ifs_rx_state_t next_rx_state;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [3:0] rx_cnt;
    logic [3:0] next_rx_cnt;
    logic rx_chan;
    logic next_rx_chan;
    logic rx_valid;
    logic next_rx_valid;
    logic cts;
    logic next_cts;
    logic rx_busy;
    assign rx_busy = (rx_state == IFS_RX_DATA) || (rx_state == IFS_RX_CHAN);
    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_cnt = rx_cnt;
        next_rx_chan = rx_chan;
        next_rx_valid = rx_valid;
        next_cts = cts;
        if (rx_valid && RX_READY_I) begin
            next_rx_valid = 1'b0;
        end
        if (!link_en) begin
            next_rx_state = IFS_RX_IDLE;
            next_cts = 1'b0;
        end else begin
            case (rx_state)
                IFS_RX_IDLE: begin
                    next_cts = ~rx_valid | RX_READY_I;
                    if (rise && cts && !din) begin
                        next_cts = 1'b0;
                        next_rx_cnt = IFS_CNT_RESET;
                        next_rx_state = IFS_RX_DATA;
                    end
                end
                IFS_RX_DATA: begin
                    if (rise) begin
                        next_rx_shift = {din, rx_shift[7:1]};
                        next_rx_cnt = rx_cnt + 4'h1;
                        if (rx_cnt == IFS_LAST_DATA) begin
                            next_rx_state = IFS_RX_CHAN;
                        end
                    end
                end
                IFS_RX_CHAN: begin
                    if (rise) begin
                        if (din) begin
                            next_rx_chan = CHB_MODE_I ? 1'b1 : 1'b0;
                        end else begin
                            next_rx_chan = CHA_MODE_I ? 1'b0 : 1'b1;
                        end
                        next_rx_valid = 1'b1;
                        next_rx_state = IFS_RX_HOLD;
                    end
                end
                IFS_RX_HOLD: begin
                    if (!rx_valid) begin
                        next_rx_state = IFS_RX_IDLE;
                    end
                end
                default: begin
                    next_rx_state = IFS_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rx_state <= IFS_RX_IDLE;
            rx_shift <= IFS_BYTE_RESET;
            rx_cnt <= IFS_CNT_RESET;
            rx_chan <= 1'b0;
            rx_valid <= 1'b0;
            cts <= IFS_CTS_RESET;
        end else begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_cnt <= next_rx_cnt;
            rx_chan <= next_rx_chan;
            rx_valid <= next_rx_valid;
            cts <= next_cts;
        end
    end

    // ************************************************
    // transmitter
    // ************************************************
    ifs_tx_state_t tx_state;
    ifs_tx_state_t next_tx_state;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] next_tx_cnt;
    logic tx_chan;
    logic next_tx_chan;
    logic sout;
    logic next_sout;
    logic tx_ready;
    logic next_tx_ready;
    always_comb begin
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        next_tx_chan = tx_chan;
        next_sout = sout;
        next_tx_ready = 1'b0;
        if (!link_en) begin
            next_tx_state = IFS_TX_IDLE;
            next_sout = IFS_LINE_IDLE;
        end else begin
            case (tx_state)
                IFS_TX_IDLE: begin
                    next_sout = IFS_LINE_IDLE;
                    if (TX_VALID_I && !tx_ready && !held && !rx_busy
                        && !(rise && cts && !din)) begin
                        next_tx_ready = 1'b1;
                        next_tx_shift = TX_DATA_I;
                        next_tx_chan = TX_CHAN_I;
                        next_tx_cnt = IFS_CNT_RESET;
                        next_sout = 1'b0;
                        next_tx_state = IFS_TX_START;
                    end
                end
                IFS_TX_START: begin
                    // a fall before the start is sampled must not shift
                    if (rise) begin
                        next_tx_cnt = 4'h1;
                    end else if (fall && tx_cnt != IFS_CNT_RESET) begin
                        next_sout = tx_shift[0];
                        next_tx_shift = {1'b0, tx_shift[7:1]};
                        next_tx_cnt = IFS_CNT_RESET;
                        next_tx_state = IFS_TX_DATA;
                    end
                end
                IFS_TX_DATA: begin
                    if (fall) begin
                        next_tx_cnt = tx_cnt + 4'h1;
                        if (tx_cnt == IFS_LAST_DATA) begin
                            next_sout = tx_chan;
                            next_tx_state = IFS_TX_CHAN;
                        end else begin
                            next_sout = tx_shift[0];
                            next_tx_shift = {1'b0, tx_shift[7:1]};
                        end
                    end
                end
                IFS_TX_CHAN: begin
                    if (fall) begin
                        next_sout = IFS_LINE_IDLE;
                        next_tx_state = IFS_TX_IDLE;
                    end
                end
                default: begin
                    next_tx_state = IFS_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            tx_state <= IFS_TX_IDLE;
            tx_shift <= IFS_BYTE_RESET;
            tx_cnt <= IFS_CNT_RESET;
            tx_chan <= 1'b0;
            sout <= IFS_LINE_IDLE;
            tx_ready <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            tx_chan <= next_tx_chan;
            sout <= next_sout;
            tx_ready <= next_tx_ready;
        end
    end

    // ************************************************
    // status flops and outputs
    // ************************************************
    logic pins_b;
    logic hold_out;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pins_b <= 1'b0;
            hold_out <= 1'b0;
        end else begin
            pins_b <= link_en;
            hold_out <= held;
        end
    end

    assign TX_READY_O = tx_ready;
    assign RX_VALID_O = rx_valid;
    assign RX_DATA_O = rx_shift;
    assign RX_CHAN_O = rx_chan;
    assign SERIAL_OUT_LINE_O = sout;
    assign LINK_CLEAR_TO_SEND_O = cts;
    assign LINK_PINS_ON_B_O = pins_b;
    assign LINK_HELD_O = hold_out;

    // ************************************************
    // assertions
    // ************************************************
    a_start_low: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (tx_state == IFS_TX_IDLE && next_tx_state == IFS_TX_START)
        |=> !SERIAL_OUT_LINE_O)
        else $error("start bit not low");
    a_no_tx_rx: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        $rose(TX_READY_O) |-> !$past(rx_busy))
        else $error("transmit began during reception");
    a_held_quiet: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        held |=> !TX_READY_O)
        else $error("byte taken while held");
    a_cts_drop: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (rx_state == IFS_RX_IDLE && link_en && rise && cts && !din)
        |=> !LINK_CLEAR_TO_SEND_O)
        else $error("cts did not drop");
    a_cts_held: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        RX_VALID_O |-> !LINK_CLEAR_TO_SEND_O)
        else $error("cts high with byte pending");
    a_idle_high: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (tx_state == IFS_TX_IDLE && $past(tx_state) == IFS_TX_IDLE)
        |-> SERIAL_OUT_LINE_O)
        else $error("line low between frames");
    a_chan_bit: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (tx_state == IFS_TX_CHAN) |-> SERIAL_OUT_LINE_O == tx_chan)
        else $error("source channel bit wrong");
    a_route_fb: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        $rose(RX_VALID_O) && CHA_MODE_I && !CHB_MODE_I
        |-> !RX_CHAN_O)
        else $error("byte routed to idle channel");
    a_disabled: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        !link_en |=> !LINK_CLEAR_TO_SEND_O && !LINK_PINS_ON_B_O)
        else $error("link active while disabled");
    a_lsb_first: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (tx_state == IFS_TX_START && fall && tx_cnt != IFS_CNT_RESET)
        |=> SERIAL_OUT_LINE_O == $past(tx_shift[0]))
        else $error("first data bit not lsb");
endmodule : ifs_link

//--- bench/ifs_far_end.sv
// far-end model: owns the link clock, sends and takes frames
`timescale 1ns/100ps
module ifs_far_end (
    // link pins seen from the far end
    output logic link_clk_o,
    output logic data_o,
    input wire logic data_i,
    input wire logic cts_i
);
    localparam time HALF = 40;
    initial begin
        link_clk_o = 1'b0;
        data_o = 1'b1;
    end
    // clock stands still between frames
    task automatic pulse();
        #HALF link_clk_o = 1'b1;
        #HALF link_clk_o = 1'b0;
    endtask : pulse
    // rude ignores clear-to-send on purpose
    task automatic send(input logic [7:0] b, input logic destination_channel_bit,
                        input logic rude, output logic ok);
        logic [9:0] fr;
        fr = {destination_channel_bit, b, 1'b0};
        ok = cts_i;
        if (ok || rude) begin
            for (int i = 0; i < 10; i++) begin
                data_o = fr[i];
                pulse();
            end
        end
        data_o = 1'b1;
    endtask : send
    // wait for start bit, stall if told, sample on each rise
    task automatic take(input int stall, output logic [9:0] fr);
        fr = 10'h3ff;
        for (int t = 0; t < 500 && data_i !== 1'b0; t++) #8;
        if (data_i === 1'b0) begin
            #(stall);
            for (int i = 0; i < 10; i++) begin
                #HALF fr[i] = data_i;
                link_clk_o = 1'b1;
                #HALF link_clk_o = 1'b0;
            end
        end
    endtask : take
endmodule : ifs_far_end

//--- bench/ifs_link_tb.sv
// testbench: link device end driven by the far-end model
`timescale 1ns/100ps
module ifs_link_tb;
    import ifs_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cha_mode = 1'b1;
    logic chb_mode = 1'b1;
    logic mode_wr = 1'b0;
    logic [3:0] mode_val = IFS_MODE_RUN;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_chan = 1'b0;
    logic rx_ready = 1'b0;
    logic tx_ready, rx_valid, rx_chan, lclk, s_in, s_out, cts, pins_b, hold;
    logic [7:0] rx_data;
    int n_fail = 0;
    int checked = 0;

    always #4 core_clk = ~core_clk;

    ifs_link u_dut (
        .CORE_CLK_I(core_clk), .NRST_I(nrst), .CHA_MODE_I(cha_mode),
        .CHB_MODE_I(chb_mode), .MODE_WR_I(mode_wr), .MODE_VAL_I(mode_val),
        .TX_VALID_I(tx_valid), .TX_DATA_I(tx_data), .TX_CHAN_I(tx_chan),
        .TX_READY_O(tx_ready), .RX_VALID_O(rx_valid), .RX_DATA_O(rx_data),
        .RX_CHAN_O(rx_chan), .RX_READY_I(rx_ready),
        .LINK_CLOCK_IN_I(lclk), .SERIAL_IN_LINE_I(s_in),
        .SERIAL_OUT_LINE_O(s_out), .LINK_CLEAR_TO_SEND_O(cts),
        .LINK_PINS_ON_B_O(pins_b), .LINK_HELD_O(hold)
    );
    ifs_far_end u_far (.link_clk_o(lclk), .data_o(s_in), .data_i(s_out),
        .cts_i(cts));

    // ***********************
    // shared tasks
    // ***********************
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk1(input logic got, input logic exp, input string s);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask : chk1
    task automatic chk10(input logic [9:0] got, input logic [9:0] exp,
                         input string s);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h", $time, s, got);
        end
    endtask : chk10
    task automatic mode_cmd(input logic [3:0] v);
        mode_wr = 1'b1;
        mode_val = v;
        tick(1);
        mode_wr = 1'b0;
        tick(3);
    endtask : mode_cmd
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // ***********************
    // scenarios
    // ***********************
    task automatic xfer(input logic [7:0] b, input logic ch, input int stall);
        logic [9:0] fr;
        tx_valid = 1'b1;
        tx_data = b;
        tx_chan = ch;
        fork
            u_far.take(stall, fr);
            begin
                for (int k = 0; k < 300 && tx_ready !== 1'b1; k++) tick(1);
                tx_valid = 1'b0;
            end
        join
        chk10(fr, {ch, b, 1'b0}, "out frame");
        #100 chk1(s_out, IFS_LINE_IDLE, "out idle");
        tick(1);
        $display("xfer done");
    endtask : xfer
    task automatic rx_case(input logic a, input logic bm, input logic destination_channel_bit,
                           input logic [7:0] b, input logic exp_ch);
        logic ok;
        cha_mode = a;
        chb_mode = bm;
        tick(4);
        chk1(pins_b, 1'b1, "pins on b");
        chk1(cts, 1'b1, "cts idle");
        fork
            u_far.send(b, destination_channel_bit, 1'b0, ok);
            begin
                @(posedge lclk);
                #40 chk1(cts, 1'b0, "cts drop");
            end
        join
        for (int k = 0; k < 20 && rx_valid !== 1'b1; k++) tick(1);
        chk10({1'b0, rx_chan, rx_data}, {1'b0, exp_ch, b}, "in");
        tick(20);
        chk1(cts, 1'b0, "cts held");
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        tick(3);
        chk1(cts, 1'b1, "cts back");
        $display("rx case done");
    endtask : rx_case
    task automatic no_tx_in_rx();
        logic ok;
        logic bad;
        logic [9:0] fr;
        bad = 1'b0;
        fork
            begin
                u_far.send(8'h96, 1'b1, 1'b0, ok);
                for (int k = 0; k < 20 && rx_valid !== 1'b1; k++) tick(1);
                rx_ready = 1'b1;
                tick(1);
                rx_ready = 1'b0;
            end
            begin
                @(posedge lclk);
                // offer the byte once the incoming start has been seen
                for (int j = 0; j < 10 && cts !== 1'b0; j++) tick(1);
                tx_valid = 1'b1;
                tx_data = 8'h5a;
                tx_chan = 1'b0;
                for (int k = 0; k < 300 && tx_ready !== 1'b1; k++) begin
                    if (k < 80 && s_out !== 1'b1) bad = 1'b1;
                    tick(1);
                end
                tx_valid = 1'b0;
            end
        join
        u_far.take(0, fr);
        chk1(bad, 1'b0, "tx during rx");
        chk10(fr, {1'b0, 8'h5a, 1'b0}, "queued frame");
        tick(4);
        $display("rx blocks tx done");
    endtask : no_tx_in_rx
    task automatic held_case();
        mode_cmd(IFS_MODE_RESET);
        chk1(hold, 1'b1, "held");
        tx_valid = 1'b1;
        tx_data = 8'hc3;
        tx_chan = 1'b1;
        repeat (40) begin
            tick(1);
            chk1(tx_ready | ~s_out, 1'b0, "sent while held");
        end
        tx_valid = 1'b0;
        mode_cmd(IFS_MODE_RUN);
        chk1(hold, 1'b0, "released");
        xfer(8'hc3, 1'b1, 0);
    endtask : held_case
    task automatic off_link();
        logic ok;
        cha_mode = 1'b0;
        chb_mode = 1'b0;
        tick(4);
        chk1(pins_b, 1'b0, "pins freed");
        chk1(cts, 1'b0, "cts off");
        u_far.send(8'h11, 1'b0, 1'b1, ok);
        tick(1);
        tx_valid = 1'b1;
        repeat (40) begin
            tick(1);
            chk1(rx_valid | tx_ready | ~s_out, 1'b0, "link active");
        end
        tx_valid = 1'b0;
        $display("link off done");
    endtask : off_link

    initial begin
        #200000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        tick(1);
        chk1(s_out, IFS_LINE_IDLE, "reset line");
        chk1(cts, IFS_CTS_RESET, "reset cts");
        tick(2);
        nrst = 1'b1;
        tick(3);
        chk1(cts, 1'b1, "cts after reset");
        chk1(pins_b, 1'b1, "pins after reset");
        xfer(8'ha5, 1'b0, 0);
        xfer(8'h3c, 1'b1, 300);
        rx_case(1'b1, 1'b1, 1'b0, 8'h81, 1'b0);
        rx_case(1'b1, 1'b1, 1'b1, 8'h7e, 1'b1);
        rx_case(1'b0, 1'b1, 1'b0, 8'h42, 1'b1);
        rx_case(1'b1, 1'b0, 1'b1, 8'h24, 1'b0);
        no_tx_in_rx();
        held_case();
        off_link();
        end_sim();
    end
endmodule : ifs_link_tb
